// ### logic/rcb_regs.svh
// Constants for the registered command buffer with parity checking.
// Assumes inclusion by bare name from package and design files.
`ifndef RCB_REGS_SVH
`define RCB_REGS_SVH

// ---------------------------------------------------------------
// Widths
// ---------------------------------------------------------------
`define RCB_CA_WIDTH 22
`define RCB_CS_WIDTH 2
`define RCB_CKE_WIDTH 2
`define RCB_ODT_WIDTH 2

// ---------------------------------------------------------------
// Buffering and status
// ---------------------------------------------------------------
`define RCB_FIFO_DEPTH 4
`define RCB_ERR_CNT_WIDTH 8

// ---------------------------------------------------------------
// Reset and idle values
// ---------------------------------------------------------------
`define RCB_CA_RESET 22'h000000
`define RCB_CS_RESET 2'h0
`define RCB_CTRL_RESET 2'h0
`define RCB_CS_IDLE 2'h3

`endif

// ### logic/rcb_pkg.sv
// Types used by the registered command buffer; its FIFO is generic and does not import them.
// Assumes rcb_regs.svh is on the include path.
`include "rcb_regs.svh"

package rcb_pkg;

  // ---------------------------------------------------------------
  // One captured clock edge worth of pin state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic load;
    logic [`RCB_CA_WIDTH-1:0] cmd_addr;
    logic [`RCB_CS_WIDTH-1:0] cs_n;
    logic [`RCB_CKE_WIDTH-1:0] cke;
    logic [`RCB_ODT_WIDTH-1:0] odt;
  } rcb_word_type;

  // ---------------------------------------------------------------
  // Error flag sequencer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RCB_PERR_IDLE,
    RCB_PERR_HOLD1,
    RCB_PERR_HOLD2
  } rcb_perr_state_type;

endpackage

// ### logic/rcb_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module rcb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
  localparam logic [PTR_W:0] FULL_CNT = (PTR_W + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PTR_W-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [PTR_W:0] cnt_reg, cnt_next;
  logic push, pop;

  // ---------------------------------------------------------------
  // Flags and handshakes
  // ---------------------------------------------------------------
  assign o_in_ready = (cnt_reg != FULL_CNT);
  assign o_out_valid = (cnt_reg != '0);
  assign o_out_data = mem_reg[rd_reg];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // Next pointers, count and storage
  always_comb begin
    mem_next = mem_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wr_reg] = i_in_data;
      wr_next = (wr_reg == LAST) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == LAST) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  // Storage is not cleared; only pointers and count need a defined reset
  always_ff @(posedge i_sys_clk) begin
    mem_reg <= mem_next;
    if (!i_rstn) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

endmodule

`default_nettype wire

// ### logic/rcb_top.sv
// Registered command/address buffer with parity check and two output banks.
// Assumes the controller logic shares i_sys_clk; only the static gate
// enable strap is treated as asynchronous.
//
// Contract
// - Parity covers all 22 command/address bits plus the parity input.
// - Parity error shown by driving the open-drain flag low.
// - Error flag stays low for two consecutive cycles.
// - Error flag delayed one extra cycle after parity evaluation.
// - Gate enable high: command/address taken only when a chip select is low.
// - Gate enable low: command/address taken on every edge.
// - All captures happen on the rising clock edge.
// - Reset clears all storage except the FIFO memory and the strap synchroniser, and forces re-driven outputs low.
// - Reset clears the parity error, releasing the flag.
// - In reset all outputs low except the error flag, which stays high.
// - Clock enable and termination re-driven on every word drained from the FIFO, never gated by chip select.
`timescale 1ns/1ps
`default_nettype none
`include "rcb_regs.svh"

module rcb_top
  import rcb_pkg::*;
#(
  parameter int FIFO_DEPTH = `RCB_FIFO_DEPTH,
  parameter int ERR_CNT_WIDTH = `RCB_ERR_CNT_WIDTH
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [`RCB_CA_WIDTH-1:0] i_cmd_addr_in,
  input wire logic i_chip_select0_in_n,
  input wire logic i_chip_select1_in_n,
  input wire logic i_clk_enable0_in,
  input wire logic i_clk_enable1_in,
  input wire logic i_termination0_in,
  input wire logic i_termination1_in,
  input wire logic i_parity_in,
  input wire logic i_select_gate_enable,
  input wire logic i_drain_ready,
  output logic [`RCB_CA_WIDTH-1:0] o_cmd_addr_out_bank_a,
  output logic [`RCB_CA_WIDTH-1:0] o_cmd_addr_out_bank_b,
  output logic [`RCB_CS_WIDTH-1:0] o_chip_select_out_bank_a_n,
  output logic [`RCB_CS_WIDTH-1:0] o_chip_select_out_bank_b_n,
  output logic [`RCB_CKE_WIDTH-1:0] o_clk_enable_out_bank_a,
  output logic [`RCB_CKE_WIDTH-1:0] o_clk_enable_out_bank_b,
  output logic [`RCB_ODT_WIDTH-1:0] o_termination_out_bank_a,
  output logic [`RCB_ODT_WIDTH-1:0] o_termination_out_bank_b,
  output logic o_parity_error_n_out,
  output logic o_parity_error_n_oe,
  output logic o_parity_error_n,
  output logic o_capture_ready,
  output logic o_overflow,
  output logic [ERR_CNT_WIDTH-1:0] o_error_count
);

  localparam int WORD_W = $bits(rcb_word_type);
  localparam logic [ERR_CNT_WIDTH-1:0] CNT_MAX = '1;

  // ---------------------------------------------------------------
  // Gate enable strap synchroniser
  // ---------------------------------------------------------------
  // The strap is a slow static level from outside the clock domain;
  // only the second stage is read by logic.
  logic gate_meta_reg, gate_meta_next;
  logic gate_sync_reg, gate_sync_next;

  always_comb begin
    gate_meta_next = i_select_gate_enable;
    gate_sync_next = gate_meta_reg;
  end

  // Not reset: the reset edges flush the strap through both stages, so
  // gating is already in force at the first edge after release
  always_ff @(posedge i_sys_clk) begin
    gate_meta_reg <= gate_meta_next;
    gate_sync_reg <= gate_sync_next;
  end

  // ---------------------------------------------------------------
  // Input capture stage
  // ---------------------------------------------------------------
  rcb_word_type cap_reg, cap_next;
  logic cap_valid_reg, cap_valid_next;
  logic chk_en_reg, chk_en_next;
  logic sel_active;

  // A command is present when at least one chip select is low
  assign sel_active = !(i_chip_select0_in_n && i_chip_select1_in_n);

  always_comb begin
    cap_next = cap_reg;
    cap_next.cs_n = {i_chip_select1_in_n, i_chip_select0_in_n};
    cap_next.cke = {i_clk_enable1_in, i_clk_enable0_in};
    cap_next.odt = {i_termination1_in, i_termination0_in};
    cap_next.load = sel_active || !gate_sync_reg;
    cap_next.cmd_addr = i_cmd_addr_in;
    // The checker looks only at words that came with a chip select
    chk_en_next = sel_active;
    cap_valid_next = 1'b1;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      cap_reg <= '{load: 1'b0, cmd_addr: `RCB_CA_RESET, cs_n: `RCB_CS_RESET,
                   cke: `RCB_CTRL_RESET, odt: `RCB_CTRL_RESET};
      cap_valid_reg <= 1'b0;
      chk_en_reg <= 1'b0;
    end else begin
      cap_reg <= cap_next;
      cap_valid_reg <= cap_valid_next;
      chk_en_reg <= chk_en_next;
    end
  end

  // ---------------------------------------------------------------
  // Parity evaluation
  // ---------------------------------------------------------------
  // The parity pin now belongs to the word held in cap_reg, one edge old.
  logic perr_eval_reg, perr_eval_next;
  logic perr_dly_reg, perr_dly_next;
  logic odd_sum;

  assign odd_sum = ^{cap_reg.cmd_addr, i_parity_in};

  always_comb begin
    perr_eval_next = chk_en_reg && odd_sum;
    perr_dly_next = perr_eval_reg;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      perr_eval_reg <= 1'b0;
      perr_dly_reg <= 1'b0;
    end else begin
      perr_eval_reg <= perr_eval_next;
      perr_dly_reg <= perr_dly_next;
    end
  end

  // ---------------------------------------------------------------
  // Error flag sequencer
  // ---------------------------------------------------------------
  // A new error during the hold restarts the two-cycle window, so
  // back-to-back errors keep the flag low without a gap.
  rcb_perr_state_type perr_state_reg, perr_state_next;
  logic perr_oe_reg, perr_oe_next, perr_n_reg, perr_n_next;
  logic [ERR_CNT_WIDTH-1:0] err_cnt_reg, err_cnt_next;

  always_comb begin
    perr_state_next = perr_state_reg;
    case (perr_state_reg)
      RCB_PERR_IDLE: begin
        if (perr_dly_reg) begin
          perr_state_next = RCB_PERR_HOLD1;
        end
      end
      RCB_PERR_HOLD1: begin
        perr_state_next = perr_dly_reg ? RCB_PERR_HOLD1 : RCB_PERR_HOLD2;
      end
      RCB_PERR_HOLD2: begin
        perr_state_next = perr_dly_reg ? RCB_PERR_HOLD1 : RCB_PERR_IDLE;
      end
      default: begin
        perr_state_next = RCB_PERR_IDLE;
      end
    endcase
    perr_oe_next = (perr_state_next != RCB_PERR_IDLE);
    perr_n_next = !perr_oe_next;
    // Saturating count so software sees errors it missed
    err_cnt_next = err_cnt_reg;
    if (perr_dly_reg && (err_cnt_reg != CNT_MAX)) begin
      err_cnt_next = err_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      perr_state_reg <= RCB_PERR_IDLE;
      perr_oe_reg <= 1'b0;
      perr_n_reg <= 1'b1;
      err_cnt_reg <= '0;
    end else begin
      perr_state_reg <= perr_state_next;
      perr_oe_reg <= perr_oe_next;
      perr_n_reg <= perr_n_next;
      err_cnt_reg <= err_cnt_next;
    end
  end

  // ---------------------------------------------------------------
  // Word FIFO between capture and output stage
  // ---------------------------------------------------------------
  // The FIFO absorbs stalls of the drain side; the cost is latency,
  // which is fixed at two edges while i_drain_ready stays high.
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [WORD_W-1:0] fifo_out_data;
  rcb_word_type drain_word;
  logic drain_take;

  rcb_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_in_valid(cap_valid_reg),
    .o_in_ready(fifo_in_ready),
    .i_in_data(cap_reg),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(i_drain_ready),
    .o_out_data(fifo_out_data)
  );

  assign drain_word = rcb_word_type'(fifo_out_data);
  assign drain_take = fifo_out_valid && i_drain_ready;

  // ---------------------------------------------------------------
  // Flow status
  // ---------------------------------------------------------------
  // A word offered while full is lost; the sticky flag records it
  // until reset since the pins cannot be held back.
  logic ready_reg, ready_next;
  logic ovf_reg, ovf_next;

  always_comb begin
    ready_next = fifo_in_ready;
    ovf_next = ovf_reg || (cap_valid_reg && !fifo_in_ready);
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      ready_reg <= 1'b0;
      ovf_reg <= 1'b0;
    end else begin
      ready_reg <= ready_next;
      ovf_reg <= ovf_next;
    end
  end

  // ---------------------------------------------------------------
  // Output stage, two banks
  // ---------------------------------------------------------------
  logic [`RCB_CA_WIDTH-1:0] ca_a_reg, ca_a_next, ca_b_reg, ca_b_next;
  logic [`RCB_CS_WIDTH-1:0] cs_a_reg, cs_a_next, cs_b_reg, cs_b_next;
  logic [`RCB_CKE_WIDTH-1:0] cke_a_reg, cke_a_next, cke_b_reg, cke_b_next;
  logic [`RCB_ODT_WIDTH-1:0] odt_a_reg, odt_a_next, odt_b_reg, odt_b_next;

  always_comb begin
    ca_a_next = ca_a_reg;
    ca_b_next = ca_b_reg;
    cs_a_next = cs_a_reg;
    cs_b_next = cs_b_reg;
    cke_a_next = cke_a_reg;
    cke_b_next = cke_b_reg;
    odt_a_next = odt_a_reg;
    odt_b_next = odt_b_reg;
    if (drain_take) begin
      cs_a_next = drain_word.cs_n;
      cs_b_next = drain_word.cs_n;
      cke_a_next = drain_word.cke;
      cke_b_next = drain_word.cke;
      odt_a_next = drain_word.odt;
      odt_b_next = drain_word.odt;
      if (drain_word.load) begin
        ca_a_next = drain_word.cmd_addr;
        ca_b_next = drain_word.cmd_addr;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      ca_a_reg <= `RCB_CA_RESET;
      ca_b_reg <= `RCB_CA_RESET;
      cs_a_reg <= `RCB_CS_RESET;
      cs_b_reg <= `RCB_CS_RESET;
      cke_a_reg <= `RCB_CTRL_RESET;
      cke_b_reg <= `RCB_CTRL_RESET;
      odt_a_reg <= `RCB_CTRL_RESET;
      odt_b_reg <= `RCB_CTRL_RESET;
    end else begin
      ca_a_reg <= ca_a_next;
      ca_b_reg <= ca_b_next;
      cs_a_reg <= cs_a_next;
      cs_b_reg <= cs_b_next;
      cke_a_reg <= cke_a_next;
      cke_b_reg <= cke_b_next;
      odt_a_reg <= odt_a_next;
      odt_b_reg <= odt_b_next;
    end
  end

  // ---------------------------------------------------------------
  // Port drive
  // ---------------------------------------------------------------
  assign o_cmd_addr_out_bank_a = ca_a_reg;
  assign o_cmd_addr_out_bank_b = ca_b_reg;
  assign o_chip_select_out_bank_a_n = cs_a_reg;
  assign o_chip_select_out_bank_b_n = cs_b_reg;
  assign o_clk_enable_out_bank_a = cke_a_reg;
  assign o_clk_enable_out_bank_b = cke_b_reg;
  assign o_termination_out_bank_a = odt_a_reg;
  assign o_termination_out_bank_b = odt_b_reg;
  // Open drain: data is always low, only the enable moves
  assign o_parity_error_n_out = 1'b0;
  assign o_parity_error_n_oe = perr_oe_reg;
  assign o_parity_error_n = perr_n_reg; // Resolved level for observers
  assign o_capture_ready = ready_reg;
  assign o_overflow = ovf_reg;
  assign o_error_count = err_cnt_reg;

endmodule

`default_nettype wire

// ### tb/rcb_top_monitor.sv
// Port checker for the registered command buffer.
// Assumes a bind to rcb_top, one clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "rcb_regs.svh"
module rcb_top_monitor #(
  parameter int ERR_CNT_WIDTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [`RCB_CA_WIDTH-1:0] i_cmd_addr_in,
  input wire logic i_chip_select0_in_n,
  input wire logic i_chip_select1_in_n,
  input wire logic i_parity_in,
  input wire logic [`RCB_CA_WIDTH-1:0] o_cmd_addr_out_bank_a,
  input wire logic [`RCB_CA_WIDTH-1:0] o_cmd_addr_out_bank_b,
  input wire logic [`RCB_CS_WIDTH-1:0] o_chip_select_out_bank_a_n,
  input wire logic [`RCB_CS_WIDTH-1:0] o_chip_select_out_bank_b_n,
  input wire logic o_parity_error_n_out,
  input wire logic o_parity_error_n_oe,
  input wire logic o_parity_error_n,
  input wire logic o_capture_ready,
  input wire logic o_overflow,
  input wire logic [ERR_CNT_WIDTH-1:0] o_error_count
);
  // ----------------
  // Properties
  // ----------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  property p_flag_hold;
    $fell(o_parity_error_n) |=> !o_parity_error_n;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag shorter than two");
  // Odd sum of word at E and parity at E+1 shows after edge E+3
  property p_err_lat;
    $past(i_rstn) && !($past(i_chip_select0_in_n) && $past(i_chip_select1_in_n))
      && (^$past(i_cmd_addr_in) ^ i_parity_in) |-> ##3 !o_parity_error_n;
  endproperty
  a_err_lat: assert property (p_err_lat) else $error("parity error missed");
  property p_err_cause;
    $rose(o_parity_error_n_oe) |-> (^$past(i_cmd_addr_in, 4) ^ $past(i_parity_in, 3))
      && !($past(i_chip_select0_in_n, 4) && $past(i_chip_select1_in_n, 4));
  endproperty
  a_err_cause: assert property (p_err_cause) else $error("false parity error");
  property p_count;
    $rose(o_parity_error_n_oe) && !(&$past(o_error_count))
      |-> o_error_count == $past(o_error_count) + 1'b1;
  endproperty
  a_count: assert property (p_count) else $error("error count not stepped");
  // Own disable: this one watches the reset itself
  property p_rst;
    disable iff (1'b0) !i_rstn |=> o_cmd_addr_out_bank_a == '0 && o_parity_error_n
      && o_chip_select_out_bank_a_n == '0 && !o_overflow && o_error_count == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_banks;
    o_cmd_addr_out_bank_a == o_cmd_addr_out_bank_b
      && o_chip_select_out_bank_a_n == o_chip_select_out_bank_b_n;
  endproperty
  a_banks: assert property (p_banks) else $error("banks differ");
  property p_resolve;
    o_parity_error_n == !o_parity_error_n_oe && o_parity_error_n_out == 1'b0;
  endproperty
  a_resolve: assert property (p_resolve) else $error("open drain flag wrong");
  property p_ovf;
    o_overflow |=> o_overflow;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not sticky");
  c_err: cover property ($fell(o_parity_error_n));
  c_ovf: cover property ($rose(o_overflow));
  c_cnt: cover property (o_error_count > 1);
endmodule
bind rcb_top rcb_top_monitor #(.ERR_CNT_WIDTH(ERR_CNT_WIDTH)) u_mon (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_cmd_addr_in(i_cmd_addr_in),
  .i_chip_select0_in_n(i_chip_select0_in_n), .i_chip_select1_in_n(i_chip_select1_in_n),
  .i_parity_in(i_parity_in), .o_cmd_addr_out_bank_a(o_cmd_addr_out_bank_a),
  .o_cmd_addr_out_bank_b(o_cmd_addr_out_bank_b),
  .o_chip_select_out_bank_a_n(o_chip_select_out_bank_a_n),
  .o_chip_select_out_bank_b_n(o_chip_select_out_bank_b_n),
  .o_parity_error_n_out(o_parity_error_n_out), .o_parity_error_n_oe(o_parity_error_n_oe),
  .o_parity_error_n(o_parity_error_n), .o_capture_ready(o_capture_ready),
  .o_overflow(o_overflow), .o_error_count(o_error_count));
`default_nettype wire

// ### tb/rcb_ctrl_model.sv
// Memory controller model driving command, selects and late parity.
// Assumes one call of send or idle per clock, back to back.
`timescale 1ns/1ps
`default_nettype none
`include "rcb_regs.svh"
module rcb_ctrl_model (
  input wire logic i_sys_clk,
  output logic [`RCB_CA_WIDTH-1:0] o_cmd_addr,
  output logic [1:0] o_cs_n,
  output logic [3:0] o_ctl,
  output logic o_parity
);
  logic pend;
  // Quiet, deselected start
  initial begin
    o_cmd_addr = '0;
    o_cs_n = 2'h3;
    o_ctl = 4'h0;
    o_parity = 1'b0;
    pend = 1'b0;
  end
  // word now, parity one edge later
  task automatic send(input logic [21:0] ca, input logic [1:0] cs, input logic bad,
                      input logic [3:0] ctl);
    @(posedge i_sys_clk);
    #1;
    o_parity = pend;
    o_cmd_addr = ca;
    o_cs_n = cs;
    o_ctl = ctl;
    pend = ^ca ^ bad;
  endtask
  // Deselected lines flip so no stale copy can pass for a hold
  task automatic idle();
    send(~o_cmd_addr, 2'h3, 1'b0, ~o_ctl);
  endtask
endmodule
`default_nettype wire

// ### tb/rcb_top_tb.sv
// Self-checking bench for the registered command buffer.
// Assumes the controller model supplies all pin traffic.
`timescale 1ns/1ps
`default_nettype none
`include "rcb_regs.svh"
module rcb_top_tb;
  logic clk, rstn, gate, drain, par;
  logic [21:0] ca, ca_a, ca_b;
  logic [1:0] cs, cs_a, cs_b, cke_a, cke_b, odt_a, odt_b;
  logic [3:0] ctl;
  logic err_od, err_oe, err_n, cap_rdy, ovf;
  logic [7:0] cnt, errs_exp;
  int err_total, n_compared;
  // ----------------
  // Clock and parts
  // ----------------
  always #20 clk = ~clk;
  rcb_ctrl_model i_ctrl (.i_sys_clk(clk), .o_cmd_addr(ca), .o_cs_n(cs), .o_ctl(ctl),
    .o_parity(par));
  rcb_top i_dut (.i_sys_clk(clk), .i_rstn(rstn), .i_cmd_addr_in(ca),
    .i_chip_select0_in_n(cs[0]), .i_chip_select1_in_n(cs[1]), .i_clk_enable0_in(ctl[0]),
    .i_clk_enable1_in(ctl[1]), .i_termination0_in(ctl[2]), .i_termination1_in(ctl[3]),
    .i_parity_in(par), .i_select_gate_enable(gate), .i_drain_ready(drain),
    .o_cmd_addr_out_bank_a(ca_a), .o_cmd_addr_out_bank_b(ca_b),
    .o_chip_select_out_bank_a_n(cs_a), .o_chip_select_out_bank_b_n(cs_b),
    .o_clk_enable_out_bank_a(cke_a), .o_clk_enable_out_bank_b(cke_b),
    .o_termination_out_bank_a(odt_a), .o_termination_out_bank_b(odt_b),
    .o_parity_error_n_out(err_od), .o_parity_error_n_oe(err_oe), .o_parity_error_n(err_n),
    .o_capture_ready(cap_rdy), .o_overflow(ovf), .o_error_count(cnt));
  // ----------------
  // Tasks
  // ----------------
  task automatic chk(input string what, input logic [21:0] seen, input logic [21:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Three low edges also flush the strap synchroniser
  task automatic do_reset(input logic g);
    @(posedge clk);
    #1;
    rstn = 1'b0;
    gate = g;
    repeat (3) @(posedge clk);
    #1;
    rstn = 1'b1;
    errs_exp = 8'h00;
    chk("ca_a", ca_a, 22'h000000);
    chk("cs_b", cs_b, 2'h0);
    chk("err_n", err_n, 1'b1);
    chk("ovf", ovf, 1'b0);
    chk("cnt", cnt, 8'h00);
  endtask
  // One word, then the full output and flag timeline
  task automatic xfer(input logic [21:0] w, input logic [1:0] c, input logic bad,
                      input logic [3:0] k, input logic [21:0] exp_ca);
    logic e;
    e = bad && (c != 2'h3);
    errs_exp = errs_exp + 8'(e);
    i_ctrl.send(w, c, bad, k);
    repeat (3) i_ctrl.idle();
    chk("ca_a", ca_a, exp_ca);
    chk("ca_b", ca_b, exp_ca);
    chk("cs_a", cs_a, c);
    chk("cke_b", cke_b, k[1:0]);
    chk("odt_a", odt_a, k[3:2]);
    chk("cke_a", cke_a, k[1:0]);
    chk("odt_b", odt_b, k[3:2]);
    chk("cap_rdy", cap_rdy, 1'b1);
    chk("err_n", err_n, 1'b1);
    i_ctrl.idle();
    chk("err_n", err_n, !e);
    i_ctrl.idle();
    chk("err_n", err_n, !e);
    i_ctrl.idle();
    chk("err_n", err_n, 1'b1);
    chk("cnt", cnt, errs_exp);
  endtask
  // Hang guard
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  // ----------------
  // Main sequence
  // ----------------
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    gate = 1'b0;
    drain = 1'b1;
    err_total = 0;
    n_compared = 0;
    errs_exp = 8'h00;
    do_reset(1'b0);
    // Gate off: every select pattern passes, parity table
    for (int i = 0; i < 8; i++) begin
      xfer(22'h155555 >> i, 2'(i), i[2], 4'(i * 5), 22'h155555 >> i);
    end
    xfer(22'h200000, 2'h2, 1'b1, 4'h9, 22'h200000);
    xfer(22'h000001, 2'h1, 1'b0, 4'h6, 22'h000001);
    // Gate on: unselected word leaves the address held
    do_reset(1'b1);
    xfer(22'h0F0F0F, 2'h1, 1'b0, 4'hA, 22'h0F0F0F);
    xfer(22'h30F0F0, 2'h3, 1'b1, 4'h3, 22'h0F0F0F);
    xfer(22'h123456, 2'h2, 1'b1, 4'hC, 22'h123456);
    // Stalled drain overfills the FIFO, then reset lands mid error
    drain = 1'b0;
    for (int i = 0; i < 7; i++) begin
      i_ctrl.send(22'(i), 2'h2, i == 6, 4'h0);
    end
    repeat (4) i_ctrl.idle();
    chk("cap_rdy", cap_rdy, 1'b0);
    chk("ovf", ovf, 1'b1);
    chk("err_n", err_n, 1'b0);
    drain = 1'b1;
    do_reset(1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
